// file: include/pes_pkg.sv
`default_nettype none

package pes_pkg;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_DIR = 8'h00;
	localparam logic [7:0] ADDR_PIN = 8'h04;
	localparam logic [7:0] ADDR_LAT = 8'h08;
	localparam logic [7:0] ADDR_ANA = 8'h0C;
	localparam logic [7:0] ADDR_SPDATA = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int DIR_IWW = 7;
	localparam int DIR_OWP = 6;
	localparam int DIR_OVR = 5;
	localparam int DIR_SPS = 4;
	localparam logic [2:0] DIR_RESET = 3'h7;
	localparam logic [3:0] ANA_RESET = 4'h0;
	localparam logic [3:0] ANA_DIGITAL_MIN = 4'hA;
	localparam int IRQ_SP = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Carried types
	// ----------------------------------------
	typedef struct packed {
		logic rd_n;
		logic wr_n;
		logic cs_n;
	} pes_strobe_t;

	typedef struct packed {
		logic [2:0] dir;
		logic [2:0] lat;
		logic [3:0] ana;
		logic sps;
		logic iww;
		logic owp;
		logic ovr;
		logic [7:0] in_word;
		logic [7:0] out_word;
		logic wr_act;
		logic rd_act;
		logic irq_stat;
		logic irq_mask;
		logic aw_ok;
		logic w_ok;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [2:0] pin_out;
		logic [2:0] pin_oe_n;
		logic [7:0] data_out;
		logic data_oe_n;
	} pes_state_t;

endpackage : pes_pkg

`default_nettype wire

// file: rtl/pes_port.sv
// Summary of operation
// - Input-word-waiting flag, bit 7, read-only.
// - Output-word-pending high until external read.
// - Overrun set on write while word waiting.
// - Mode bit selects slave port operation.
// - Direction bit 3 reads zero, ignores writes.
// - Pins 0-2 direction bits, reset to input.
// - Output direction drives pin from latch.
// - Input reads pin unless analog selected.
// - Pins become read, write, select strobes.
// - Pins default to analog after reset.
// - Pin 3 is master clear when configured.
// - Pin 3 input only, read when config zero.
// - Upper pin and latch bits read zero.
// - Write ends on strobe high, sets flags.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module pes_port (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Port pins
	input wire logic [2:0] port_pin_i,
	output logic [2:0] port_pin_o,
	output logic [2:0] port_pin_oe_n_o,
	input wire logic port_pin3_input_i,
	input wire logic master_clear_config_i,
	output logic master_clear_n_o,
	// Slave port data bus
	input wire logic [7:0] sp_data_i,
	output logic [7:0] sp_data_o,
	output logic sp_data_oe_n_o,
	// Interrupt
	output logic irq_o
);

	pes_pkg::pes_state_t st;
	pes_pkg::pes_state_t next_st;
	pes_pkg::pes_strobe_t stb;
	logic [2:0] dig_en;
	logic wr_sel;
	logic rd_sel;
	logic sp_on;
	logic aw_fire;
	logic w_fire;
	logic ar_fire;
	logic do_wr;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic rd_hit;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// A pin's digital input is live only when the analog field leaves it digital.
	function automatic logic [2:0] digital_pins(input logic [3:0] ana);
		digital_pins = (ana >= pes_pkg::ANA_DIGITAL_MIN) ? 3'h7 : 3'h0;
	endfunction : digital_pins

	// Only the aligned words of the seven mapped registers answer with an okay response.
	function automatic logic reg_known(input logic [7:0] addr);
		case (addr)
			pes_pkg::ADDR_DIR, pes_pkg::ADDR_PIN, pes_pkg::ADDR_LAT, pes_pkg::ADDR_ANA: reg_known = 1'b1;
			pes_pkg::ADDR_SPDATA, pes_pkg::ADDR_IRQ_STAT, pes_pkg::ADDR_IRQ_MASK: reg_known = 1'b1;
			default: reg_known = 1'b0;
		endcase
	endfunction : reg_known

	// ----------------------------------------
	// Combinational next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		dig_en = digital_pins(st.ana);
		sp_on = st.sps && (st.dir == 3'h7);
		// Strobes read high (idle) while the digital input is disabled.
		stb.rd_n = port_pin_i[0] | ~dig_en[0];
		stb.wr_n = port_pin_i[1] | ~dig_en[1];
		stb.cs_n = port_pin_i[2] | ~dig_en[2];
		wr_sel = sp_on && !stb.cs_n && !stb.wr_n;
		rd_sel = sp_on && !stb.cs_n && !stb.rd_n;
		aw_fire = s_axi_awvalid_i && !st.aw_ok;
		w_fire = s_axi_wvalid_i && !st.w_ok;
		ar_fire = s_axi_arvalid_i && !st.rvalid;
		if (aw_fire) begin
			next_st.aw_ok = 1'b1;
			next_st.aw_addr = s_axi_awaddr_i;
		end
		if (w_fire) begin
			next_st.w_ok = 1'b1;
			next_st.w_data = s_axi_wdata_i;
			next_st.w_strb = s_axi_wstrb_i;
		end
		do_wr = st.aw_ok && st.w_ok && !st.bvalid;
		wbyte = st.w_data[7:0];
		// External write: capture while active, flag on the end.
		next_st.wr_act = wr_sel;
		if (wr_sel) begin
			next_st.in_word = sp_data_i;
		end
		if (st.wr_act && !wr_sel) begin
			if (st.iww) begin
				next_st.ovr = 1'b1;
			end
			next_st.iww = 1'b1;
			next_st.irq_stat = 1'b1;
		end
		// External read: drive the out word, clear pending at start.
		next_st.rd_act = rd_sel;
		if (rd_sel && !st.rd_act) begin
			next_st.owp = 1'b0;
		end
		if (st.rd_act && !rd_sel) begin
			next_st.irq_stat = 1'b1;
		end
		// Software write; hardware sets above win over clears here.
		if (do_wr && st.w_strb[0]) begin
			case (st.aw_addr)
				pes_pkg::ADDR_DIR: begin
					next_st.dir = wbyte[2:0];
					next_st.sps = wbyte[pes_pkg::DIR_SPS];
					next_st.ovr = wbyte[pes_pkg::DIR_OVR] | (st.wr_act && !wr_sel && st.iww);
				end
				pes_pkg::ADDR_LAT: next_st.lat = wbyte[2:0];
				pes_pkg::ADDR_ANA: next_st.ana = wbyte[3:0];
				pes_pkg::ADDR_SPDATA: begin
					next_st.out_word = wbyte;
					// A write during an active external read is taken at once.
					next_st.owp = !rd_sel;
				end
				pes_pkg::ADDR_IRQ_STAT: begin
					if (wbyte[pes_pkg::IRQ_SP] && !(st.wr_act && !wr_sel) && !(st.rd_act && !rd_sel)) begin
						next_st.irq_stat = 1'b0;
					end
				end
				pes_pkg::ADDR_IRQ_MASK: next_st.irq_mask = wbyte[pes_pkg::IRQ_SP];
				default: begin
				end
			endcase
		end
		if (do_wr) begin
			next_st.aw_ok = 1'b0;
			next_st.w_ok = 1'b0;
			next_st.bvalid = 1'b1;
			// The pin register only reflects pin levels, so a write to it is refused.
			next_st.bresp = (reg_known(st.aw_addr) && st.aw_addr != pes_pkg::ADDR_PIN)
				? pes_pkg::RESP_OKAY : pes_pkg::RESP_SLVERR;
		end else if (st.bvalid && s_axi_bready_i) begin
			next_st.bvalid = 1'b0;
		end
		// Register read.
		rbyte = 8'h00;
		rd_hit = reg_known(s_axi_araddr_i);
		case (s_axi_araddr_i)
			pes_pkg::ADDR_DIR: rbyte = {st.iww, st.owp, st.ovr, st.sps, 1'b0, st.dir};
			pes_pkg::ADDR_PIN: begin
				rbyte[2:0] = port_pin_i & dig_en;
				rbyte[3] = port_pin3_input_i & ~master_clear_config_i;
			end
			pes_pkg::ADDR_LAT: rbyte = {5'h00, st.lat};
			pes_pkg::ADDR_ANA: rbyte = {4'h0, st.ana};
			pes_pkg::ADDR_SPDATA: rbyte = st.in_word;
			pes_pkg::ADDR_IRQ_STAT: rbyte = {7'h00, st.irq_stat};
			pes_pkg::ADDR_IRQ_MASK: rbyte = {7'h00, st.irq_mask};
			default: rbyte = 8'h00;
		endcase
		if (ar_fire) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = {24'h000000, rbyte};
			next_st.rresp = rd_hit ? pes_pkg::RESP_OKAY : pes_pkg::RESP_SLVERR;
			if (s_axi_araddr_i == pes_pkg::ADDR_SPDATA) begin
				next_st.iww = (st.wr_act && !wr_sel);
			end
		end else if (st.rvalid && s_axi_rready_i) begin
			next_st.rvalid = 1'b0;
		end
		// Pin drivers.
		next_st.pin_out = next_st.lat;
		next_st.pin_oe_n = next_st.dir;
		next_st.data_out = next_st.out_word;
		next_st.data_oe_n = !rd_sel;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
			st.dir <= pes_pkg::DIR_RESET;
			st.ana <= pes_pkg::ANA_RESET;
			st.pin_oe_n <= pes_pkg::DIR_RESET;
			st.data_oe_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready_o = !st.aw_ok;
	assign s_axi_wready_o = !st.w_ok;
	assign s_axi_bvalid_o = st.bvalid;
	assign s_axi_bresp_o = st.bresp;
	assign s_axi_arready_o = !st.rvalid;
	assign s_axi_rvalid_o = st.rvalid;
	assign s_axi_rdata_o = st.rdata;
	assign s_axi_rresp_o = st.rresp;
	assign port_pin_o = st.pin_out;
	assign port_pin_oe_n_o = st.pin_oe_n;
	// Pin 3 passes through as reset request only when configured so.
	assign master_clear_n_o = master_clear_config_i ? port_pin3_input_i : 1'b1;
	assign sp_data_o = st.data_out;
	assign sp_data_oe_n_o = st.data_oe_n;
	assign irq_o = st.irq_stat & st.irq_mask;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_iww_on_end: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(st.wr_act && !wr_sel) |=> st.iww && st.irq_stat)
		else $error("write end did not set flags");
	a_ovr_on_again: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(st.wr_act && !wr_sel && st.iww) |=> st.ovr)
		else $error("overrun not flagged");
	a_ovr_sticky: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(st.ovr && !do_wr) |=> st.ovr)
		else $error("overrun dropped without write");
	a_owp_read_clr: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(rd_sel && !st.rd_act && !do_wr) |=> !st.owp)
		else $error("pending not cleared by read");
	a_pin_drive: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(do_wr && st.w_strb[0] && st.aw_addr == pes_pkg::ADDR_LAT) |=> port_pin_o == $past(st.w_data[2:0]))
		else $error("latch value not on pins");
	a_pin_dir: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(do_wr && st.w_strb[0] && st.aw_addr == pes_pkg::ADDR_DIR) |=> port_pin_oe_n_o == $past(st.w_data[2:0]))
		else $error("pin enables do not follow direction");
	a_dir_bit3: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(ar_fire && s_axi_araddr_i == pes_pkg::ADDR_DIR) |=> !s_axi_rdata_o[3])
		else $error("direction bit 3 not zero");
	a_pin_upper: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(ar_fire && s_axi_araddr_i == pes_pkg::ADDR_PIN) |=> s_axi_rdata_o[7:4] == 4'h0)
		else $error("pin upper bits not zero");
	a_pin3_master_clear_n: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(ar_fire && s_axi_araddr_i == pes_pkg::ADDR_PIN && master_clear_config_i) |=> !s_axi_rdata_o[3])
		else $error("pin 3 read while master clear");
	a_strobe_mode: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		wr_sel |-> st.sps && st.dir == 3'h7)
		else $error("write strobe outside slave mode");
	a_analog_off: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(st.ana < pes_pkg::ANA_DIGITAL_MIN) |-> !wr_sel && !rd_sel)
		else $error("strobe seen while analog");

	// ----------------------------------------
	// Checks on flag life cycle
	// ----------------------------------------
	// Each flag may only move on its own set or clear event.
	a_iww_read_clr: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(ar_fire && s_axi_araddr_i == pes_pkg::ADDR_SPDATA && !(st.wr_act && !wr_sel)) |=> !st.iww)
		else $error("input word flag not cleared by read");
	a_iww_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(st.iww && !ar_fire) |=> st.iww)
		else $error("input word flag dropped without read");
	a_iww_set_only: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(!st.iww && !(st.wr_act && !wr_sel)) |=> !st.iww)
		else $error("input word flag set without write end");
	a_owp_on_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(do_wr && st.w_strb[0] && st.aw_addr == pes_pkg::ADDR_SPDATA && !rd_sel) |=> st.owp)
		else $error("pending flag not set by write");
	a_owp_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(st.owp && !rd_sel) |=> st.owp)
		else $error("pending flag dropped without read");
	a_ovr_sw_clr: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(do_wr && st.w_strb[0] && st.aw_addr == pes_pkg::ADDR_DIR && !st.w_data[pes_pkg::DIR_OVR]
		&& !(st.wr_act && !wr_sel && st.iww)) |=> !st.ovr)
		else $error("overrun not cleared by software");
	a_ovr_set_only: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(!st.ovr && !do_wr && !(st.wr_act && !wr_sel && st.iww)) |=> !st.ovr)
		else $error("overrun set without cause");
	a_irq_read_end: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(st.rd_act && !rd_sel) |=> st.irq_stat)
		else $error("read end did not set interrupt");
	a_irq_sticky: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(st.irq_stat && !do_wr) |=> st.irq_stat)
		else $error("interrupt status dropped without write");

	// ----------------------------------------
	// Checks on register access and pins
	// ----------------------------------------
	// Read data is compared with what the pins showed at the accepting edge.
	a_mode_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(do_wr && st.w_strb[0] && st.aw_addr == pes_pkg::ADDR_DIR)
		|=> st.sps == $past(st.w_data[pes_pkg::DIR_SPS]))
		else $error("mode bit not written");
	a_dir_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(do_wr && st.w_strb[0] && st.aw_addr == pes_pkg::ADDR_DIR) |=> st.dir == $past(st.w_data[2:0]))
		else $error("direction bits not written");
	a_lat_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(do_wr && st.w_strb[0] && st.aw_addr == pes_pkg::ADDR_LAT) |=> st.lat == $past(st.w_data[2:0]))
		else $error("latch not written");
	a_pin_analog: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(ar_fire && s_axi_araddr_i == pes_pkg::ADDR_PIN && st.ana < pes_pkg::ANA_DIGITAL_MIN)
		|=> s_axi_rdata_o[2:0] == 3'h0)
		else $error("analog pins read as digital");
	a_pin_level: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(ar_fire && s_axi_araddr_i == pes_pkg::ADDR_PIN && st.ana >= pes_pkg::ANA_DIGITAL_MIN)
		|=> s_axi_rdata_o[2:0] == $past(port_pin_i))
		else $error("pin levels not returned");
	a_pin3_read: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(ar_fire && s_axi_araddr_i == pes_pkg::ADDR_PIN && !master_clear_config_i)
		|=> s_axi_rdata_o[3] == $past(port_pin3_input_i))
		else $error("pin 3 level not returned");
	a_lat_upper: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(ar_fire && s_axi_araddr_i == pes_pkg::ADDR_LAT) |=> s_axi_rdata_o[7:3] == 5'h00)
		else $error("latch upper bits not zero");
	a_in_capture: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		wr_sel |=> st.in_word == $past(sp_data_i))
		else $error("external word not captured");
	a_read_drive: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		rd_sel |=> !sp_data_oe_n_o)
		else $error("data bus not driven during read");

endmodule : pes_port

`default_nettype wire

// file: verification/pes_ext_cpu.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// External processor on the slave port
// ----------------------------------------
module pes_ext_cpu (
	// Clock
	input wire logic clk_i,
	// Strobe pins {select, write, read} and data bus
	output logic [2:0] pin_o,
	output logic [7:0] data_o,
	input wire logic [7:0] data_i,
	input wire logic oe_n_i
);
	initial begin
		pin_o = 3'h7;
		data_o = 8'h00;
	end

	task automatic drive(input logic [2:0] p, input logic [7:0] d);
		@(posedge clk_i);
		pin_o <= p;
		data_o <= d;
	endtask : drive

	// A released bus shows the inverse of the last word.
	task automatic ext_write(input logic [7:0] d);
		drive(3'h1, d);
		repeat (3) @(posedge clk_i);
		drive(3'h7, ~d);
	endtask : ext_write

	task automatic ext_read(output logic [7:0] d);
		drive(3'h2, data_o);
		repeat (3) @(posedge clk_i);
		d = oe_n_i ? 8'h00 : data_i;
		drive(3'h7, data_o);
	endtask : ext_read
endmodule : pes_ext_cpu

`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic core_clk_i, sys_rst_i, pin3, mc_cfg, mc_n, sp_oe_n, irq;
	logic [7:0] awaddr, araddr, sp_in, sp_out, ext_v;
	logic [31:0] wdata, rdata, rd_v;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, rsp;
	logic [2:0] pin_in, pin_out, pin_oe_n;
	int err_count, checked, cyc;

	pes_port i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.port_pin_i(pin_in), .port_pin_o(pin_out), .port_pin_oe_n_o(pin_oe_n),
		.port_pin3_input_i(pin3), .master_clear_config_i(mc_cfg), .master_clear_n_o(mc_n),
		.sp_data_i(sp_in), .sp_data_o(sp_out), .sp_data_oe_n_o(sp_oe_n), .irq_o(irq));

	pes_ext_cpu i_ext (.clk_i(core_clk_i), .pin_o(pin_in), .data_o(sp_in), .data_i(sp_out), .oe_n_i(sp_oe_n));

	// ----------------------------------------
	// Bus cycles and comparison
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr_e(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge core_clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", e, bresp);
	endtask : wr_e

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wr_e(a, d, pes_pkg::RESP_OKAY);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge core_clk_i);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a, rd_v, rsp);
		chk(n, e, rd_v);
		chk("rresp", pes_pkg::RESP_OKAY, rsp);
	endtask : rchk

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk("outputs after reset", 32'h1E, {pin_oe_n, sp_oe_n, irq});
		rchk("direction reset", pes_pkg::ADDR_DIR, 32'h07);
		rchk("latch reset", pes_pkg::ADDR_LAT, 32'h0);
		rchk("analog reset", pes_pkg::ADDR_ANA, 32'h0);
		rchk("pins analog", pes_pkg::ADDR_PIN, 32'h08);
		rd(8'h1C, rd_v, rsp);
		chk("unmapped resp", pes_pkg::RESP_SLVERR, rsp);
		chk("unmapped data", 32'h0, rd_v);
	endtask : t_reset

	task automatic t_gpio;
		wr(pes_pkg::ADDR_DIR, 32'h08);
		rchk("direction out", pes_pkg::ADDR_DIR, 32'h00);
		wr(pes_pkg::ADDR_LAT, 32'hFF);
		rchk("latch", pes_pkg::ADDR_LAT, 32'h07);
		chk("pin drive", 32'h07, {pin_oe_n, pin_out});
		wr(pes_pkg::ADDR_DIR, 32'h07);
		wr(pes_pkg::ADDR_ANA, 32'h0F);
		i_ext.drive(3'h5, 8'h00);
		mc_cfg <= 1'b1;
		pin3 <= 1'b0;
		rchk("pins clear cfg", pes_pkg::ADDR_PIN, 32'h05);
		chk("master clear low", 32'h0, mc_n);
		mc_cfg <= 1'b0;
		pin3 <= 1'b1;
		rchk("pins pin3", pes_pkg::ADDR_PIN, 32'h0D);
		chk("master clear idle", 32'h1, mc_n);
		rchk("latch kept", pes_pkg::ADDR_LAT, 32'h07);
		i_ext.drive(3'h7, 8'h00);
	endtask : t_gpio

	task automatic t_slave;
		wr(pes_pkg::ADDR_DIR, 32'h17);
		wr(pes_pkg::ADDR_SPDATA, 32'hA5);
		rchk("out pending", pes_pkg::ADDR_DIR, 32'h57);
		i_ext.ext_read(ext_v);
		chk("external read", 32'hA5, ext_v);
		rchk("out read", pes_pkg::ADDR_DIR, 32'h17);
		wr(pes_pkg::ADDR_IRQ_STAT, 32'h1);
		i_ext.ext_write(8'h3C);
		rchk("in waiting", pes_pkg::ADDR_DIR, 32'h97);
		rchk("irq status", pes_pkg::ADDR_IRQ_STAT, 32'h1);
		chk("irq masked", 32'h0, irq);
		wr(pes_pkg::ADDR_IRQ_MASK, 32'h1);
		rchk("mask", pes_pkg::ADDR_IRQ_MASK, 32'h1);
		chk("irq raised", 32'h1, irq);
		i_ext.ext_write(8'h5A);
		rchk("overrun", pes_pkg::ADDR_DIR, 32'hB7);
		rchk("in word", pes_pkg::ADDR_SPDATA, 32'h5A);
		rchk("in read", pes_pkg::ADDR_DIR, 32'h37);
		wr(pes_pkg::ADDR_DIR, 32'h17);
		rchk("overrun clear", pes_pkg::ADDR_DIR, 32'h17);
		wr(pes_pkg::ADDR_IRQ_STAT, 32'h1);
		rchk("irq cleared", pes_pkg::ADDR_IRQ_STAT, 32'h0);
		chk("irq low", 32'h0, irq);
	endtask : t_slave

	// Strobes must be ignored unless all three pins are digital inputs.
	task automatic t_guard;
		wr_e(pes_pkg::ADDR_PIN, 32'h07, pes_pkg::RESP_SLVERR);
		wr_e(8'h02, 32'h07, pes_pkg::RESP_SLVERR);
		wr(pes_pkg::ADDR_DIR, 32'h13);
		chk("pin 2 driven", 32'h3, pin_oe_n);
		i_ext.ext_write(8'h11);
		rchk("write needs inputs", pes_pkg::ADDR_DIR, 32'h13);
		wr(pes_pkg::ADDR_DIR, 32'h17);
		wr(pes_pkg::ADDR_ANA, 32'h09);
		i_ext.ext_write(8'h22);
		rchk("write needs digital", pes_pkg::ADDR_DIR, 32'h17);
		rchk("no irq", pes_pkg::ADDR_IRQ_STAT, 32'h0);
		wr(pes_pkg::ADDR_ANA, 32'h0A);
		i_ext.ext_write(8'h33);
		rchk("digital range start", pes_pkg::ADDR_DIR, 32'h97);
		rchk("in word range start", pes_pkg::ADDR_SPDATA, 32'h33);
		wr(pes_pkg::ADDR_IRQ_STAT, 32'h1);
		rchk("irq cleared again", pes_pkg::ADDR_IRQ_STAT, 32'h0);
	endtask : t_guard

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic finish_test;
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	// The whole run needs well under a thousand cycles.
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			$display("[FAIL] cycle count expected below %0d seen %0d", 5000, cyc);
			err_count++;
			finish_test();
		end
	end

	initial begin
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, mc_cfg} = '0;
		{err_count, checked, cyc} = '0;
		wstrb = 4'hF;
		pin3 = 1'b1;
		sys_rst_i = 1'b1;
		repeat (4) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_gpio();
		t_slave();
		t_guard();
		finish_test();
	end
endmodule : testbench

`default_nettype wire
